// ===== rtl/dbc_boot_cfg.sv
// boot configuration word decoder with run-time jtag copy
// Operation
// - permission bit per group 0..2 allows debug access
// - denied group in debug mode uses group 3
// - in sleep mode, flash sleep bit or regulator standby powers down flash
// - boot isa bit sets exception flag, isa field
// - trace bit enables cpu trace
// - channel code picks debug pin pair
// - reset copies jtag config into run-time bit
// - config zero blocks setting run-time jtag
// - config one lets software toggle jtag
// - debugger field selects jtag, pins, debug unit
// - code protection forces debugger field to 11
// - either jtag bit zero blocks 4-wire jtag
`timescale 1ns/1ps
module dbc_boot_cfg (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic [31:0] CFG_WORD,
  input  wire logic        CODE_PROTECT,
  input  wire logic        JTAG_FUSE,
  input  wire logic        DEBUG_MODE,
  input  wire logic        REG_STANDBY,
  input  wire logic        SLEEP_MODE,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic      [2:0]  ALLOW_GROUPS,
  output logic      [1:0]  BUS_GROUP,
  output logic             FLASH_POWERDOWN,
  output logic             EXC_ISA_FLAG,
  output logic      [1:0]  CORE_ISA,
  output logic             TRACE_EN,
  output logic      [2:0]  PAIR_SEL,
  output logic             JTAG_PORT_EN,
  output logic             TWO_WIRE_EN,
  output logic             DEBUG_UNIT_EN
);
  import dbc_pkg::*;

  typedef struct packed {
    dbc_state_t  st;
    logic [31:0] word;
    logic        cp;
    logic        rt_jtag;
    logic [1:0]  perm_sel;
    logic [31:0] rdata;
    logic        fpd;
    logic        excf;
    logic [1:0]  isa;
    logic        trc;
    logic [2:0]  pair;
    logic        jtag_on;
    logic        two_wire;
    logic        dbg_unit;
  } dbc_regs_t;

  dbc_regs_t r_q, r_d;
  logic [1:0] dbg_field;
  logic [1:0] group_out;

  // the gate registers its own result; BUS_GROUP is that flop
  dbc_perm_gate u_gate (
    .CLK        (CLK),
    .RST        (RST),
    .ce         (CE),
    .allow      (r_q.word[POS_PERM_LO +: 3]),
    .debug_mode (DEBUG_MODE),
    .group_sel  (r_q.perm_sel),
    .group_out  (group_out)
  );

  always_comb begin
    r_d       = r_q;
    dbg_field = r_q.cp ? DEBUG_FORCED : r_q.word[POS_DEBUG_LO +: 2];
    case (r_q.st)
      DBC_ST_RESET: begin
        // the word is only sampled once, after reset releases
        r_d.word    = CFG_WORD;
        r_d.cp      = CODE_PROTECT;
        r_d.rt_jtag = CFG_WORD[POS_JTAG_CFG];
        r_d.st      = DBC_ST_RUN;
      end
      DBC_ST_RUN: begin
        if (WR && ADDR == OFS_RUNTIME) begin
          // setting only sticks when the config bit allows it
          r_d.rt_jtag = WDATA[POS_RT_JTAG] & r_q.word[POS_JTAG_CFG];
        end
        if (WR && ADDR == OFS_PERM_SEL) begin
          r_d.perm_sel = WDATA[1:0];
        end
      end
      default: begin
        r_d.st = DBC_ST_RESET;
      end
    endcase
    // decoded outputs
    r_d.fpd  = SLEEP_MODE && (r_q.word[POS_FLASH_SLEEP_POWERDOWN] || REG_STANDBY);
    r_d.excf = !r_q.word[POS_BOOT_ISA];
    r_d.isa  = r_q.word[POS_BOOT_ISA] ? ISA_FULL : ISA_COMPACT;
    r_d.trc  = r_q.word[POS_TRACE];
    case (r_q.word[POS_CHAN_LO +: 2])
      CHAN_PAIR1: r_d.pair = 3'h1;
      CHAN_PAIR2: r_d.pair = 3'h2;
      CHAN_PAIR3: r_d.pair = 3'h4;
      // reserved code: no pair connected
      default:    r_d.pair = 3'h0;
    endcase
    r_d.jtag_on  = dbg_field[1] && JTAG_FUSE && r_q.rt_jtag;
    r_d.two_wire = !dbg_field[1];
    r_d.dbg_unit = !dbg_field[0];
    // register read port, data one cycle after the strobe
    r_d.rdata = '0;
    if (RD) begin
      case (ADDR)
        OFS_CFG_WORD: r_d.rdata = r_q.word;
        OFS_RUNTIME:  r_d.rdata = {28'h0, r_q.rt_jtag, 3'h0};
        OFS_STATUS:   r_d.rdata = {24'h0, r_q.cp, JTAG_FUSE, dbg_field,
                                   r_q.jtag_on, r_q.two_wire, r_q.dbg_unit, r_q.trc};
        OFS_PERM_SEL: r_d.rdata = {30'h0, r_q.perm_sel};
        default:      r_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      r_q       <= '0;
      r_q.word  <= RESET_WORD;
      r_q.st    <= DBC_ST_RESET;
    end else if (CE) begin
      r_q <= r_d;
    end
  end

  assign RDATA           = r_q.rdata;
  assign ALLOW_GROUPS    = r_q.word[POS_PERM_LO +: 3];
  assign BUS_GROUP       = group_out;
  assign FLASH_POWERDOWN = r_q.fpd;
  assign EXC_ISA_FLAG    = r_q.excf;
  assign CORE_ISA        = r_q.isa;
  assign TRACE_EN        = r_q.trc;
  assign PAIR_SEL        = r_q.pair;
  assign JTAG_PORT_EN    = r_q.jtag_on;
  assign TWO_WIRE_EN     = r_q.two_wire;
  assign DEBUG_UNIT_EN   = r_q.dbg_unit;

  sequence s_leave_reset;
    r_q.st == DBC_ST_RESET && CE;
  endsequence

  a_rt_copy: assert property (@(posedge CLK) disable iff (RST)
    s_leave_reset |=> r_q.rt_jtag == $past(CFG_WORD[POS_JTAG_CFG]))
    else $error("run-time jtag not copied at reset");
  a_rt_blocked: assert property (@(posedge CLK) disable iff (RST)
    r_q.st == DBC_ST_RUN && !r_q.word[POS_JTAG_CFG] |-> !r_q.rt_jtag)
    else $error("run-time jtag set while config clear");
  a_rt_write: assert property (@(posedge CLK) disable iff (RST)
    CE && r_q.st == DBC_ST_RUN && WR && ADDR == OFS_RUNTIME && r_q.word[POS_JTAG_CFG]
      |=> r_q.rt_jtag == $past(WDATA[POS_RT_JTAG]))
    else $error("run-time jtag write lost");
  a_word_hold: assert property (@(posedge CLK) disable iff (RST)
    r_q.st == DBC_ST_RUN |=> $stable(r_q.word))
    else $error("config word changed after reset");
  a_flash_pd: assert property (@(posedge CLK) disable iff (RST)
    CE |=> FLASH_POWERDOWN == $past(SLEEP_MODE && (r_q.word[POS_FLASH_SLEEP_POWERDOWN] || REG_STANDBY)))
    else $error("flash power-down wrong");
  a_isa_pair: assert property (@(posedge CLK) disable iff (RST)
    r_q.st == DBC_ST_RUN ##1 CE |=> EXC_ISA_FLAG == (CORE_ISA == ISA_COMPACT))
    else $error("isa flag and field disagree");
  a_trace_cfg: assert property (@(posedge CLK) disable iff (RST)
    CE |=> TRACE_EN == $past(r_q.word[POS_TRACE]))
    else $error("trace enable wrong");
  a_pair_sel: assert property (@(posedge CLK) disable iff (RST)
    CE && r_q.word[POS_CHAN_LO +: 2] == CHAN_PAIR2 |=> PAIR_SEL == 3'h2)
    else $error("pair 2 not selected");
  a_cp_force: assert property (@(posedge CLK) disable iff (RST)
    CE && r_q.cp |=> !TWO_WIRE_EN && !DEBUG_UNIT_EN)
    else $error("code protect did not force debugger field");
  a_jtag_gate: assert property (@(posedge CLK) disable iff (RST)
    CE && (!JTAG_FUSE || !r_q.rt_jtag) |=> !JTAG_PORT_EN)
    else $error("jtag enabled with a zero enable bit");
  a_dbg_field: assert property (@(posedge CLK) disable iff (RST)
    CE && !r_q.cp && r_q.word[1:0] == 2'h1 |=> TWO_WIRE_EN && !DEBUG_UNIT_EN)
    else $error("debugger field 01 decoded wrong");

  // building blocks for the multi-step checks below
  sequence s_rt_write;
    CE && r_q.st == DBC_ST_RUN && WR && ADDR == OFS_RUNTIME;
  endsequence
  sequence s_sel_write;
    CE && r_q.st == DBC_ST_RUN && WR && ADDR == OFS_PERM_SEL;
  endsequence
  sequence s_no_rt_write;
    CE && r_q.st == DBC_ST_RUN && !(WR && ADDR == OFS_RUNTIME);
  endsequence

  // channel decode, remaining codes including the reserved one
  a_pair_one: assert property (@(posedge CLK) disable iff (RST)
    CE && r_q.word[POS_CHAN_LO +: 2] == CHAN_PAIR1 |=> PAIR_SEL == 3'h1)
    else $error("pair 1 not selected");
  a_pair_three: assert property (@(posedge CLK) disable iff (RST)
    CE && r_q.word[POS_CHAN_LO +: 2] == CHAN_PAIR3 |=> PAIR_SEL == 3'h4)
    else $error("pair 3 not selected");
  a_pair_none: assert property (@(posedge CLK) disable iff (RST)
    CE && r_q.word[POS_CHAN_LO +: 2] == 2'h0 |=> PAIR_SEL == 3'h0)
    else $error("reserved channel code connected a pair");

  // isa selection, both settings
  a_isa_full: assert property (@(posedge CLK) disable iff (RST)
    CE && r_q.word[POS_BOOT_ISA] |=> !EXC_ISA_FLAG && CORE_ISA == ISA_FULL)
    else $error("full isa decode wrong");
  a_isa_compact: assert property (@(posedge CLK) disable iff (RST)
    CE && !r_q.word[POS_BOOT_ISA] |=> EXC_ISA_FLAG && CORE_ISA == ISA_COMPACT)
    else $error("compact isa decode wrong");

  // debugger field, remaining codes
  a_dbg_code2: assert property (@(posedge CLK) disable iff (RST)
    CE && !r_q.cp && r_q.word[1:0] == 2'h2 |=> !TWO_WIRE_EN && DEBUG_UNIT_EN)
    else $error("debugger field 10 decoded wrong");
  a_dbg_code0: assert property (@(posedge CLK) disable iff (RST)
    CE && !r_q.cp && r_q.word[1:0] == 2'h0 |=> TWO_WIRE_EN && DEBUG_UNIT_EN)
    else $error("debugger field 00 decoded wrong");
  a_dbg_code3: assert property (@(posedge CLK) disable iff (RST)
    CE && !r_q.cp && r_q.word[1:0] == 2'h3 |=> !TWO_WIRE_EN && !DEBUG_UNIT_EN)
    else $error("debugger field 11 decoded wrong");
  a_jtag_on: assert property (@(posedge CLK) disable iff (RST)
    CE && dbg_field[1] && JTAG_FUSE && r_q.rt_jtag |=> JTAG_PORT_EN)
    else $error("jtag not enabled with all bits set");
  a_jtag_field: assert property (@(posedge CLK) disable iff (RST)
    CE && !dbg_field[1] |=> !JTAG_PORT_EN && TWO_WIRE_EN)
    else $error("pin debug field still enabled jtag");

  // flash power-down, each branch on its own
  a_flash_sleep: assert property (@(posedge CLK) disable iff (RST)
    CE && SLEEP_MODE && r_q.word[POS_FLASH_SLEEP_POWERDOWN] |=> FLASH_POWERDOWN)
    else $error("flash not powered down in sleep");
  a_flash_awake: assert property (@(posedge CLK) disable iff (RST)
    CE && !SLEEP_MODE |=> !FLASH_POWERDOWN)
    else $error("flash powered down while awake");
  a_flash_vreg: assert property (@(posedge CLK) disable iff (RST)
    CE && SLEEP_MODE && !r_q.word[POS_FLASH_SLEEP_POWERDOWN] |=> FLASH_POWERDOWN == $past(REG_STANDBY))
    else $error("flash power-down ignores standby bit");

  // latched state holds after the load edge
  a_cp_hold: assert property (@(posedge CLK) disable iff (RST)
    r_q.st == DBC_ST_RUN |=> $stable(r_q.cp))
    else $error("code protect changed after reset");
  a_allow_hold: assert property (@(posedge CLK) disable iff (RST)
    r_q.st == DBC_ST_RUN |=> $stable(ALLOW_GROUPS))
    else $error("permission field changed after reset");
  a_st_stay: assert property (@(posedge CLK) disable iff (RST)
    r_q.st == DBC_ST_RUN |=> r_q.st == DBC_ST_RUN)
    else $error("decoder left run state without reset");
  a_st_legal: assert property (@(posedge CLK) disable iff (RST)
    r_q.st == DBC_ST_RUN || r_q.st == DBC_ST_RESET)
    else $error("decoder state illegal");
  a_reset_out: assert property (@(posedge CLK)
    RST |=> RDATA == 32'h0 && !JTAG_PORT_EN && PAIR_SEL == 3'h0)
    else $error("outputs not cleared by reset");
  a_freeze: assert property (@(posedge CLK) disable iff (RST)
    !CE |=> $stable(r_q))
    else $error("state moved with clock enable low");

  // run-time jtag bit writes
  a_rt_clear: assert property (@(posedge CLK) disable iff (RST)
    s_rt_write ##0 !WDATA[POS_RT_JTAG] |=> !r_q.rt_jtag)
    else $error("run-time jtag clear lost");
  a_rt_refuse: assert property (@(posedge CLK) disable iff (RST)
    s_rt_write ##0 !r_q.word[POS_JTAG_CFG] |=> !r_q.rt_jtag)
    else $error("run-time jtag set against config");
  a_rt_keep: assert property (@(posedge CLK) disable iff (RST)
    s_no_rt_write |=> $stable(r_q.rt_jtag))
    else $error("run-time jtag changed without a write");

  // permission group select register
  a_sel_write: assert property (@(posedge CLK) disable iff (RST)
    s_sel_write |=> r_q.perm_sel == $past(WDATA[1:0]))
    else $error("group select write lost");
  a_sel_keep: assert property (@(posedge CLK) disable iff (RST)
    CE && !(WR && ADDR == OFS_PERM_SEL) && r_q.st == DBC_ST_RUN |=> $stable(r_q.perm_sel))
    else $error("group select changed without a write");

  // read port: data only in the cycle after the strobe
  a_read_idle: assert property (@(posedge CLK) disable iff (RST)
    CE && !RD |=> RDATA == 32'h0)
    else $error("read data without a read strobe");
  a_read_rt: assert property (@(posedge CLK) disable iff (RST)
    CE && RD && ADDR == OFS_RUNTIME |=> RDATA == {28'h0, $past(r_q.rt_jtag), 3'h0})
    else $error("run-time register read wrong");
  a_read_word: assert property (@(posedge CLK) disable iff (RST)
    CE && RD && ADDR == OFS_CFG_WORD |=> RDATA == $past(r_q.word))
    else $error("config word read wrong");
  a_read_sel: assert property (@(posedge CLK) disable iff (RST)
    CE && RD && ADDR == OFS_PERM_SEL |=> RDATA == {30'h0, $past(r_q.perm_sel)})
    else $error("group select read wrong");
  a_read_hole: assert property (@(posedge CLK) disable iff (RST)
    CE && RD && ADDR[1:0] != 2'h0 |=> RDATA == 32'h0)
    else $error("unmapped read returned data");
endmodule : dbc_boot_cfg

// ===== rtl/dbc_pkg.sv
// constants for the boot configuration decoder
package dbc_pkg;
  // register map of the plain register port (byte addresses)
  localparam logic [3:0] OFS_CFG_WORD   = 4'h0;
  localparam logic [3:0] OFS_RUNTIME    = 4'h4;
  localparam logic [3:0] OFS_STATUS     = 4'h8;
  localparam logic [3:0] OFS_PERM_SEL   = 4'hC;
  // field positions in boot_config_word_0, plus the bit in the run-time register
  localparam int POS_DEBUG_LO   = 0;
  localparam int POS_JTAG_CFG   = 2;
  localparam int POS_CHAN_LO    = 3;
  localparam int POS_TRACE      = 5;
  localparam int POS_BOOT_ISA   = 6;
  localparam int POS_RSVD_LO    = 7;
  localparam int POS_FLASH_SLEEP_POWERDOWN     = 10;
  localparam int POS_TOOL_BIT   = 11;
  localparam int POS_PERM_LO    = 12;
  localparam int POS_RT_JTAG    = 3;
  // fixed encodings
  localparam logic [1:0] ISA_FULL      = 2'h2;
  localparam logic [1:0] ISA_COMPACT   = 2'h3;
  localparam logic [1:0] PERM_GROUP3   = 2'h3;
  localparam logic [1:0] DEBUG_FORCED  = 2'h3;
  localparam logic [1:0] CHAN_PAIR1    = 2'h3;
  localparam logic [1:0] CHAN_PAIR2    = 2'h2;
  localparam logic [1:0] CHAN_PAIR3    = 2'h1;
  localparam logic [2:0] RSVD_ONES     = 3'h7;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  typedef enum logic [1:0] {
    DBC_ST_RESET = 2'b00,
    DBC_ST_RUN   = 2'b01
  } dbc_state_t;
endpackage : dbc_pkg

// ===== rtl/dbc_perm_gate.sv
// debug-mode permission group gate
`timescale 1ns/1ps
module dbc_perm_gate (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       ce,
  input  wire logic [2:0] allow,
  input  wire logic       debug_mode,
  input  wire logic [1:0] group_sel,
  output logic      [1:0] group_out
);
  import dbc_pkg::*;
  typedef struct packed {
    logic [1:0] grp;
  } dbc_gate_t;
  dbc_gate_t s_q, s_d;
  logic      denied;
  logic [3:0] allow_ext;

  always_comb begin
    s_d       = s_q;
    // group 3 itself has no permission bit and always passes
    allow_ext = {1'b1, allow};
    denied    = !allow_ext[group_sel];
    if (debug_mode && denied) begin
      s_d.grp = PERM_GROUP3;
    end else begin
      s_d.grp = group_sel;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign group_out = s_q.grp;

  a_denied_group3: assert property (@(posedge CLK) disable iff (RST)
    ce && debug_mode && group_sel != PERM_GROUP3 && !allow[group_sel]
      |=> group_out == PERM_GROUP3)
    else $error("denied group not mapped to group 3");
  a_allowed_pass: assert property (@(posedge CLK) disable iff (RST)
    ce && (!debug_mode || group_sel == PERM_GROUP3 || allow[group_sel])
      |=> group_out == $past(group_sel))
    else $error("permitted group altered");
endmodule : dbc_perm_gate

// ===== tb/dbc_tool_model.sv
// debugger tool model: halts the cpu into debug mode, owns tool bit
`timescale 1ns/1ps
module dbc_tool_model #(
  parameter logic TOOL_BIT = 1'b1
) (
  input  wire logic CLK,
  input  wire logic halt,
  output logic      debug_mode,
  output logic      tool_bit
);
  // halt request reaches the core one clock later, like a real probe
  always_ff @(posedge CLK) begin
    debug_mode <= halt;
  end
  assign tool_bit = TOOL_BIT;
endmodule : dbc_tool_model

// ===== tb/test_debug_boot_config_decode.sv
// self-checking bench for the boot configuration decoder
`timescale 1ns/1ps
module test_debug_boot_config_decode;
  import dbc_pkg::*;
  typedef struct packed {
    logic [2:0] perm;
    logic       fs;
    logic       isa;
    logic       tr;
    logic [1:0] ch;
    logic       jt;
    logic [1:0] dbg;
    logic       cp;
    logic [2:0] pair;
  } dbc_row_t;
  localparam dbc_row_t ROWS [4] = '{
    '{3'h5, 1'h1, 1'h1, 1'h1, 2'h3, 1'h1, 2'h2, 1'h0, 3'h1},
    '{3'h2, 1'h0, 1'h0, 1'h0, 2'h2, 1'h1, 2'h1, 1'h0, 3'h2},
    '{3'h0, 1'h1, 1'h1, 1'h0, 2'h1, 1'h1, 2'h0, 1'h0, 3'h4},
    '{3'h7, 1'h0, 1'h0, 1'h1, 2'h0, 1'h0, 2'h0, 1'h1, 3'h0}};
  logic        CLK = 0, RST = 1, CE = 1, CODE_PROTECT = 0, JTAG_FUSE = 1;
  logic        REG_STANDBY = 0, SLEEP_MODE = 1, WR = 0, RD = 0, halt = 0;
  logic [31:0] CFG_WORD = 32'h0, WDATA = 32'h0, RDATA;
  logic [3:0]  ADDR = 4'h0;
  logic [2:0]  ALLOW_GROUPS, PAIR_SEL;
  logic [1:0]  BUS_GROUP, CORE_ISA, f;
  logic        FLASH_POWERDOWN, EXC_ISA_FLAG, TRACE_EN, JTAG_PORT_EN;
  logic        TWO_WIRE_EN, DEBUG_UNIT_EN, DEBUG_MODE, tool_bit;
  int          bad_count = 0, samples_checked = 0;
  dbc_row_t    r;
  dbc_tool_model i_tool (.CLK, .halt, .debug_mode(DEBUG_MODE), .tool_bit);
  dbc_boot_cfg i_dut (.CLK, .RST, .CE, .CFG_WORD, .CODE_PROTECT, .JTAG_FUSE, .DEBUG_MODE,
    .REG_STANDBY, .SLEEP_MODE, .ADDR, .WDATA, .WR, .RD, .RDATA, .ALLOW_GROUPS, .BUS_GROUP,
    .FLASH_POWERDOWN, .EXC_ISA_FLAG, .CORE_ISA, .TRACE_EN, .PAIR_SEL, .JTAG_PORT_EN,
    .TWO_WIRE_EN, .DEBUG_UNIT_EN);
  initial begin
    forever #20 CLK = ~CLK;
  end
  // reserved bits 9..7 are always programmed as ones
  function automatic logic [31:0] mk(input dbc_row_t x);
    mk = {17'h0, x.perm, tool_bit, x.fs, RSVD_ONES, x.isa, x.tr, x.ch, x.jt, x.dbg};
  endfunction : mk
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : step
  task automatic load(input dbc_row_t x, input int n);
    @(posedge CLK);
    CFG_WORD     <= mk(x);
    CODE_PROTECT <= x.cp;
    RST          <= 1'b1;
    repeat (n) @(posedge CLK);
    RST <= 1'b0;
    step(3);
  endtask : load
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    check("rdata", RDATA, exp);
  endtask : rd
  initial begin
    repeat (5000) @(posedge CLK);
    bad_count++;
    finish_test();
  end
  initial begin
    foreach (ROWS[i]) begin
      r = ROWS[i];
      load(r, (i == 0) ? 16 : 2);
      f = r.cp ? DEBUG_FORCED : r.dbg;
      check("allow", ALLOW_GROUPS, r.perm);
      check("exc_isa", EXC_ISA_FLAG, !r.isa);
      check("core_isa", CORE_ISA, r.isa ? 2'h2 : 2'h3);
      check("trace", TRACE_EN, r.tr);
      check("pair", PAIR_SEL, r.pair);
      check("flash_pd", FLASH_POWERDOWN, r.fs);
      check("two_wire", TWO_WIRE_EN, !f[1]);
      check("dbg_unit", DEBUG_UNIT_EN, !f[0]);
      check("jtag_port", JTAG_PORT_EN, f[1] & r.jt);
      rd(OFS_RUNTIME, {28'h0, r.jt, 3'h0});
    end
    wr(OFS_RUNTIME, 32'h8);
    rd(OFS_RUNTIME, 32'h0);
    REG_STANDBY <= 1'b1;
    step(2);
    check("flash_pd", FLASH_POWERDOWN, 1'b1);
    SLEEP_MODE <= 1'b0;
    step(2);
    check("flash_pd", FLASH_POWERDOWN, 1'b0);
    r = ROWS[0];
    load(r, 2);
    wr(OFS_RUNTIME, 32'h0);
    step(2);
    check("jtag_port", JTAG_PORT_EN, 1'b0);
    wr(OFS_RUNTIME, 32'h8);
    step(2);
    check("jtag_port", JTAG_PORT_EN, 1'b1);
    JTAG_FUSE <= 1'b0;
    step(2);
    check("jtag_port", JTAG_PORT_EN, 1'b0);
    CFG_WORD <= 32'h0;
    wr(OFS_CFG_WORD, 32'h0);
    step(2);
    check("allow", ALLOW_GROUPS, r.perm);
    rd(OFS_CFG_WORD, mk(r));
    rd(4'h2, 32'h0);
    // group 1 is denied by 101, group 0 allowed
    wr(OFS_PERM_SEL, 32'h1);
    halt <= 1'b1;
    step(3);
    check("bus_group", BUS_GROUP, PERM_GROUP3);
    wr(OFS_PERM_SEL, 32'h0);
    step(2);
    check("bus_group", BUS_GROUP, 2'h0);
    wr(OFS_PERM_SEL, 32'h1);
    halt <= 1'b0;
    step(3);
    check("bus_group", BUS_GROUP, 2'h1);
    rd(OFS_STATUS, {24'h0, r.cp, 1'b0, r.dbg, 1'b0, !r.dbg[1], !r.dbg[0], r.tr});
    // clock enable low must freeze the decoded outputs
    CE         <= 1'b0;
    SLEEP_MODE <= 1'b1;
    step(3);
    check("flash_pd", FLASH_POWERDOWN, 1'b0);
    CE <= 1'b1;
    step(2);
    check("flash_pd", FLASH_POWERDOWN, 1'b1);
    finish_test();
  end
endmodule : test_debug_boot_config_decode
